// ==== verilog/eeprom_defs.svh ====
// constants for the three-wire serial eeprom core
// assumes a 125 MHz system clock; included by bare name
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

`define MCLK_PERIOD_NS  8
`define PROG_TIME_NS    5000000

`define MEM_ADDR_W      10
`define MEM_BYTES       11'h400

`define X8_ADDR_END     5'h0d
`define X16_ADDR_END    5'h0c
`define X8_DATA_LEN     5'h08
`define X16_DATA_LEN    5'h10
`define X8_BYTE_STEP    10'h001
`define X16_BYTE_STEP   10'h002

`define OP_SPECIAL      2'h0
`define OP_WRITE        2'h1
`define OP_READ         2'h2
`define OP_ERASE        2'h3
`define SUB_DISABLE     2'h0
`define SUB_BULK_WRITE  2'h1
`define SUB_BULK_ERASE  2'h2
`define SUB_ENABLE      2'h3

`define ERASED_WORD     16'hffff

`define REG_CONFIG      4'h0
`define REG_STATUS      4'h4
`define CFG_RESET       2'h0
`define WSZ_FIXED8      2'h1
`define WSZ_FIXED16     2'h2

`endif

// ==== verilog/eeprom_pkg.sv ====
// types shared by the serial eeprom core
// widths written as literals; uses nothing from eeprom_defs.svh
package eeprom_pkg;

  typedef enum logic [3:0] {
    LINK_WAIT   = 4'h1,
    LINK_SHIFT  = 4'h2,
    LINK_READ   = 4'h4,
    LINK_IGNORE = 4'h8
  } link_state_t;

  typedef enum logic [1:0] {
    PROG_ERASE      = 2'h0,
    PROG_WRITE      = 2'h1,
    PROG_BULK_ERASE = 2'h2,
    PROG_BULK_WRITE = 2'h3
  } prog_op_t;

  typedef struct packed {
    logic sel;
    logic sclk;
    logic sin;
    logic wide;
  } pins_t;

  typedef struct packed {
    prog_op_t    op;
    logic [9:0]  addr;
    logic [15:0] data;
  } prog_job_t;

endpackage

// ==== verilog/pin_sync.sv ====
// two-flop synchroniser for a bundle of asynchronous pins
// assumes the bits are independent levels; no bus coherency
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= d;
      stage2_reg <= stage1_reg;
    end
  end

  assign q = stage2_reg;

endmodule

// ==== verilog/serial_eeprom_core.sv ====
// three-wire serial eeprom: command decode, array, self-timed programming
// assumes select, serial clock, serial in and word size come from pins
// of another domain; registers reached over avalon-mm with waitrequest
//
// How it works
// - erase sets addressed word to all ones
// - single erase starts at final address edge
// - status: out low busy, high ready
// - start bit then select low drops status
// - bulk erase sets array to ones, self-timed
// - bulk cycles finish without further clocks
// - power-up disabled; enable needed before programming
// - enable holds until disable or reset
// - reads run regardless of enable state
// - read gives dummy zero then word msb-first
// - read bits change on serial clock rise
// - select held high streams next addresses
// - write starts programming on last data edge
// - bulk write fills every location, enable needed
// - select low is standby; programming still completes
// - select low holds decoder in reset
// - bits sampled on rising serial clock
// - clocks without start bit change nothing
// - after command, ignore inputs until select drops
// - status after silent cycle reads ready
// - word size pin: high sixteen, low eight; config modes WSZ_FIXED8 and WSZ_FIXED16 override the pin
// - start is first rise with select and input high
// - output released except read data or status
// - opcode and special sub-code decoding
`timescale 1ns/100ps
`include "eeprom_defs.svh"
module serial_eeprom_core
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = `PROG_TIME_NS / `MCLK_PERIOD_NS
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        chipSelect,
  input  wire logic        serialClk,
  input  wire logic        serialIn,
  input  wire logic        wordSizeSelect,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             serialOut,
  output logic             serialOutEn
);

  // array, byte wide; a sixteen-bit word keeps its high byte at the even address
  logic [7:0] mem [0:(1 << `MEM_ADDR_W) - 1];
  function automatic logic [15:0] wordAt(input logic [9:0] a, input logic w);
    return w ? {mem[{a[9:1], 1'b0}], mem[{a[9:1], 1'b1}]} : {mem[a], 8'h00};
  endfunction
  // pin synchronisation
  pins_t pinsRaw;
  pins_t pinsSync;
  pins_t pinsPrev_reg;
  assign pinsRaw = '{sel: chipSelect, sclk: serialClk, sin: serialIn, wide: wordSizeSelect};
  pin_sync #(
    .WIDTH ($bits(pins_t))
  ) u_pin_sync (
    .clk (mclk),
    .rst (sys_rst),
    .d   (pinsRaw),
    .q   (pinsSync)
  );
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pinsPrev_reg <= '0;
    end else begin
      pinsPrev_reg <= pinsSync;
    end
  end
  logic sclkRise;
  logic selRise;
  logic wide;
  logic [1:0] cfgMode_reg;
  assign sclkRise = pinsSync.sclk & ~pinsPrev_reg.sclk;
  assign selRise  = pinsSync.sel & ~pinsPrev_reg.sel;
  always_comb begin
    unique case (cfgMode_reg)
      `WSZ_FIXED8:  wide = 1'b0;
      `WSZ_FIXED16: wide = 1'b1;
      default:      wide = pinsSync.wide;
    endcase
  end
  // programming engine
  logic        busy_reg,      busy_next;
  logic [31:0] timer_reg,     timer_next;
  logic [9:0]  sweepAddr_reg, sweepAddr_next;
  logic [10:0] sweepLeft_reg, sweepLeft_next;
  logic [15:0] progData_reg,  progData_next;
  logic        memWe;
  logic [7:0]  memByte;
  logic        startJob;
  prog_job_t   job;
  always_comb begin
    busy_next      = busy_reg;
    timer_next     = timer_reg;
    sweepAddr_next = sweepAddr_reg;
    sweepLeft_next = sweepLeft_reg;
    progData_next  = progData_reg;
    memWe          = 1'b0;
    memByte        = sweepAddr_reg[0] ? progData_reg[7:0] : progData_reg[15:8];
    if (startJob) begin
      busy_next  = 1'b1;
      timer_next = 32'(PROG_CYCLES);
      unique case (job.op)
        PROG_ERASE, PROG_WRITE: begin
          sweepAddr_next = job.addr;
          sweepLeft_next = wide ? 11'h002 : 11'h001;
          progData_next  = job.data;
        end
        PROG_BULK_ERASE, PROG_BULK_WRITE: begin
          sweepAddr_next = '0;
          sweepLeft_next = `MEM_BYTES;
          progData_next  = job.data;
        end
      endcase
    end else if (busy_reg) begin
      // runs on the system clock alone, serial clock not needed
      if (sweepLeft_reg != 11'h000) begin
        memWe          = 1'b1;
        sweepAddr_next = sweepAddr_reg + 10'h001;
        sweepLeft_next = sweepLeft_reg - 11'h001;
      end
      if (timer_reg != 32'h0) begin
        timer_next = timer_reg - 32'h1;
      end else if (sweepLeft_reg == 11'h000) begin
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg      <= 1'b0;
      timer_reg     <= 32'h0;
      sweepAddr_reg <= 10'h000;
      sweepLeft_reg <= 11'h000;
      progData_reg  <= 16'h0000;
    end else begin
      busy_reg      <= busy_next;
      timer_reg     <= timer_next;
      sweepAddr_reg <= sweepAddr_next;
      sweepLeft_reg <= sweepLeft_next;
      progData_reg  <= progData_next;
    end
  end
  always_ff @(posedge mclk) begin
    if (memWe) begin
      mem[sweepAddr_reg] <= memByte;
    end
  end
  // serial command link
  link_state_t state_reg,       state_next;
  logic [4:0]  bitCnt_reg,      bitCnt_next;
  logic [31:0] inShift_reg,     inShift_next;
  logic [9:0]  addr_reg,        addr_next;
  logic [15:0] outShift_reg,    outShift_next;
  logic [4:0]  outCnt_reg,      outCnt_next;
  logic        pendBulk_reg,    pendBulk_next;
  logic        progEnable_reg,  progEnable_next;
  logic        statusArmed_reg, statusArmed_next;
  logic        serialOut_reg,   serialOut_next;
  logic        serialOutEn_reg, serialOutEn_next;
  logic [31:0] shifted;
  logic [4:0]  addrEnd;
  logic [4:0]  dataEnd;
  logic [1:0]  opcode;
  logic [1:0]  subCode;
  logic [15:0] word;
  logic        progOk;
  assign shifted = {inShift_reg[30:0], pinsSync.sin};
  assign addrEnd = wide ? `X16_ADDR_END : `X8_ADDR_END;
  assign dataEnd = addrEnd + (wide ? `X16_DATA_LEN : `X8_DATA_LEN);
  assign opcode  = wide ? shifted[11:10] : shifted[12:11];
  assign subCode = wide ? shifted[9:8] : shifted[10:9];
  assign progOk  = progEnable_reg & ~busy_reg;
  always_comb begin
    state_next       = state_reg;
    bitCnt_next      = bitCnt_reg;
    inShift_next     = inShift_reg;
    addr_next        = addr_reg;
    outShift_next    = outShift_reg;
    outCnt_next      = outCnt_reg;
    pendBulk_next    = pendBulk_reg;
    progEnable_next  = progEnable_reg;
    statusArmed_next = statusArmed_reg;
    serialOut_next   = serialOut_reg;
    serialOutEn_next = serialOutEn_reg;
    startJob         = 1'b0;
    job              = '{op: PROG_ERASE, addr: addr_reg, data: `ERASED_WORD};
    word             = 16'h0000;
    if (!pinsSync.sel) begin
      state_next       = LINK_WAIT;
      bitCnt_next      = 5'h00;
      serialOutEn_next = 1'b0;
    end else begin
      if (selRise && statusArmed_reg) begin
        serialOutEn_next = 1'b1;
      end
      if (state_reg == LINK_WAIT && serialOutEn_reg) begin
        serialOut_next = ~busy_reg;
      end
      unique case (state_reg)
        LINK_WAIT: begin
          if (sclkRise && pinsSync.sin) begin
            state_next       = busy_reg ? LINK_IGNORE : LINK_SHIFT;
            bitCnt_next      = 5'h00;
            statusArmed_next = 1'b0;
            serialOutEn_next = 1'b0;
          end
        end
        LINK_SHIFT: begin
          if (sclkRise) begin
            inShift_next = shifted;
            bitCnt_next  = bitCnt_reg + 5'h01;
            if (bitCnt_next == addrEnd) begin
              addr_next  = wide ? {shifted[8:0], 1'b0} : shifted[9:0];
              state_next = LINK_IGNORE;
              unique case (opcode)
                `OP_READ: begin
                  word             = wordAt(addr_next, wide);
                  state_next       = LINK_READ;
                  serialOut_next   = 1'b0;
                  serialOutEn_next = 1'b1;
                  outShift_next    = word;
                  outCnt_next      = wide ? `X16_DATA_LEN : `X8_DATA_LEN;
                end
                `OP_WRITE: begin
                  pendBulk_next = 1'b0;
                  state_next    = LINK_SHIFT;
                end
                `OP_ERASE: begin
                  startJob = progOk;
                  job.op   = PROG_ERASE;
                  job.addr = addr_next;
                end
                default: begin
                  unique case (subCode)
                    `SUB_ENABLE:     progEnable_next = 1'b1;
                    `SUB_DISABLE:    progEnable_next = 1'b0;
                    `SUB_BULK_ERASE: begin
                      startJob = progOk;
                      job.op   = PROG_BULK_ERASE;
                    end
                    default: begin
                      pendBulk_next = 1'b1;
                      state_next    = LINK_SHIFT;
                    end
                  endcase
                end
              endcase
            end else if (bitCnt_next == dataEnd) begin
              state_next = LINK_IGNORE;
              startJob   = progOk;
              job.op     = pendBulk_reg ? PROG_BULK_WRITE : PROG_WRITE;
              job.data   = wide ? shifted[15:0] : {shifted[7:0], shifted[7:0]};
            end
          end
        end
        LINK_READ: begin
          if (sclkRise) begin
            if (outCnt_reg != 5'h00) begin
              serialOut_next = outShift_reg[15];
              outShift_next  = {outShift_reg[14:0], 1'b0};
              outCnt_next    = outCnt_reg - 5'h01;
            end else begin
              addr_next      = addr_reg + (wide ? `X16_BYTE_STEP : `X8_BYTE_STEP);
              word           = wordAt(addr_next, wide);
              serialOut_next = word[15];
              outShift_next  = {word[14:0], 1'b0};
              outCnt_next    = (wide ? `X16_DATA_LEN : `X8_DATA_LEN) - 5'h01;
            end
          end
        end
        LINK_IGNORE: begin
        end
      endcase
    end
    if (startJob) begin
      statusArmed_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg       <= LINK_WAIT;
      bitCnt_reg      <= 5'h00;
      inShift_reg     <= 32'h0;
      addr_reg        <= 10'h000;
      outShift_reg    <= 16'h0000;
      outCnt_reg      <= 5'h00;
      pendBulk_reg    <= 1'b0;
      progEnable_reg  <= 1'b0;
      statusArmed_reg <= 1'b0;
      serialOut_reg   <= 1'b0;
      serialOutEn_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      bitCnt_reg      <= bitCnt_next;
      inShift_reg     <= inShift_next;
      addr_reg        <= addr_next;
      outShift_reg    <= outShift_next;
      outCnt_reg      <= outCnt_next;
      pendBulk_reg    <= pendBulk_next;
      progEnable_reg  <= progEnable_next;
      statusArmed_reg <= statusArmed_next;
      serialOut_reg   <= serialOut_next;
      serialOutEn_reg <= serialOutEn_next;
    end
  end

  assign serialOut   = serialOut_reg;
  assign serialOutEn = serialOutEn_reg;
  // avalon-mm register slave: one wait cycle per access
  // write lands on the edge after the wait ends; read data only moves on reads
  logic        waitReq_reg,  waitReq_next;
  logic [31:0] readData_reg, readData_next;
  logic [1:0]  cfgMode_next;
  always_comb begin
    waitReq_next  = 1'b1;
    readData_next = readData_reg;
    cfgMode_next  = cfgMode_reg;
    if ((avs_read || avs_write) && waitReq_reg) begin
      waitReq_next  = 1'b0;
      if (avs_read) begin
        unique case (avs_address)
          `REG_CONFIG: readData_next = {30'h0, cfgMode_reg};
          `REG_STATUS: readData_next = {28'h0, wide, statusArmed_reg,
                                        progEnable_reg, busy_reg};
          default:     readData_next = 32'h0;
        endcase
      end
    end
    if (avs_write && !waitReq_reg && avs_address == `REG_CONFIG) begin
      cfgMode_next = avs_writedata[1:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      waitReq_reg  <= 1'b1;
      readData_reg <= 32'h0;
      cfgMode_reg  <= `CFG_RESET;
    end else begin
      waitReq_reg  <= waitReq_next;
      readData_reg <= readData_next;
      cfgMode_reg  <= cfgMode_next;
    end
  end

  assign avs_waitrequest = waitReq_reg;
  assign avs_readdata    = readData_reg;

endmodule

// ==== dv/serial_eeprom_core_sva.sv ====
// port checker for the serial eeprom core
// assumes select and serial pins change in step with mclk
`timescale 1ns/100ps
module serial_eeprom_core_sva (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        chipSelect,
  input wire logic        serialClk,
  input wire logic        serialIn,
  input wire logic        wordSizeSelect,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        serialOut,
  input wire logic        serialOutEn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_req_taken;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_req_taken: assert property (p_req_taken) else $error("request not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_no_spurious;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
  property p_rdata_hold;
    $changed(avs_readdata) |-> !avs_waitrequest && avs_read;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("readdata moved");
  property p_release;
    $fell(chipSelect) |-> ##[1:6] !serialOutEn;
  endproperty
  a_release: assert property (p_release) else $error("out not released");
  property p_standby;
    (!chipSelect) [*6] |-> !serialOutEn;
  endproperty
  a_standby: assert property (p_standby) else $error("driving while deselected");
  property p_en_select;
    $rose(serialOutEn) |-> chipSelect && $past(chipSelect, 2);
  endproperty
  a_en_select: assert property (p_en_select) else $error("drive without select");
  property p_standby_out;
    serialOutEn |-> chipSelect || $past(chipSelect, 5);
  endproperty
  a_standby_out: assert property (p_standby_out) else $error("standby drive");
endmodule
bind serial_eeprom_core serial_eeprom_core_sva i_serial_eeprom_core_sva (
  .mclk(mclk), .sys_rst(sys_rst), .chipSelect(chipSelect), .serialClk(serialClk),
  .serialIn(serialIn), .wordSizeSelect(wordSizeSelect), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .serialOut(serialOut), .serialOutEn(serialOutEn));

// ==== dv/eeprom_host_model.sv ====
// host controller model: select, serial clock, serial in, word size pin
// assumes tasks are called right after a rising mclk edge
`timescale 1ns/100ps
module eeprom_host_model
  import eeprom_pkg::*;
(
  input  wire logic mclk,
  input  wire logic serialOut,
  input  wire logic serialOutEn,
  output pins_t     pins
);
  initial pins = '0;
  // released data line floats to the inverse of the last driven bit
  logic lastOut = 1'b0;
  logic line;
  always @(posedge mclk) begin
    if (serialOutEn) begin
      lastOut <= serialOut;
    end
  end
  assign line = serialOutEn ? serialOut : ~lastOut;
  task automatic set_wide(input logic w);
    pins.wide <= w;
  endtask
  // deselect; data line shows the inverse of its last bit
  task automatic gap();
    pins.sel <= 1'b0;
    pins.sin <= ~pins.sin;
    repeat (40) @(posedge mclk);
  endtask
  // n rises, msb first; clock stands still outside the frame
  task automatic send(input int n, input logic [31:0] bits, output logic [31:0] got);
    got = '0;
    pins.sel <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int i = n - 1; i >= 0; i--) begin
      pins.sin <= bits[i];
      repeat (5) @(posedge mclk);
      pins.sclk <= 1'b1;
      repeat (10) @(posedge mclk);
      got = {got[30:0], line};
      pins.sclk <= 1'b0;
      repeat (5) @(posedge mclk);
    end
    gap();
  endtask
  task automatic status(output logic en, output logic val);
    pins.sel <= 1'b1;
    pins.sin <= 1'b0;
    repeat (8) @(posedge mclk);
    en = serialOutEn;
    val = line;
    gap();
  endtask
endmodule

// ==== dv/test_serial_eeprom_core.sv ====
// self-checking bench for the serial eeprom core
// assumes the host model and the bound port checker
`timescale 1ns/100ps
`include "eeprom_defs.svh"
module test_serial_eeprom_core
  import eeprom_pkg::*;
;
  localparam int PROG_CYCLES = 2000;
  logic        mclk;
  logic        sys_rst;
  pins_t       pins;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serialOut;
  logic        serialOutEn;
  logic [31:0] seed = 32'h08d7e748;
  logic [31:0] got;
  logic [9:0]  adr;
  logic [15:0] dat;
  logic        en;
  logic        val;
  int          bad_count = 0;
  int          cmp_count = 0;
  serial_eeprom_core #(.PROG_CYCLES(PROG_CYCLES)) i_serial_eeprom_core (
    .mclk(mclk), .sys_rst(sys_rst), .chipSelect(pins.sel), .serialClk(pins.sclk),
    .serialIn(pins.sin), .wordSizeSelect(pins.wide), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serialOut(serialOut), .serialOutEn(serialOutEn));
  eeprom_host_model i_eeprom_host_model (
    .mclk(mclk), .serialOut(serialOut), .serialOutEn(serialOutEn), .pins(pins));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [10:0] sub_field(input logic [1:0] sub);
    return pins.wide ? {1'b0, sub, 8'h00} : {sub, 9'h000};
  endfunction
  function automatic logic [10:0] adr_field(input logic [9:0] a);
    return pins.wide ? {2'b00, a[8:0]} : {1'b0, a};
  endfunction
  // dummy zero above one word
  function automatic logic [31:0] rd_exp(input logic [15:0] d);
    return pins.wide ? {16'h0000, d} : {24'h000000, d[7:0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    got = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  // status bits from bit 0 up: busy, enabled, armed, sixteen-bit
  task automatic sreg(input logic [3:0] e);
    av(1'b0, `REG_STATUS, 32'h0);
    chk(got & 32'hf, {28'h0, e});
  endtask
  // leading zero bits give clocks before the start bit
  task automatic cmd(input logic [1:0] op, input logic [10:0] af, input logic [15:0] d,
                     input int nd, input int nr);
    logic [31:0] b;
    b = pins.wide ? {20'h00001, op, af[9:0]} : {19'h00001, op, af};
    b = ((b << nd) | 32'(d)) << nr;
    i_eeprom_host_model.send(32, b, got);
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] d);
    cmd(`OP_READ, adr_field(a), 16'h0, 0, pins.wide ? 16 : 8);
    chk(got & (pins.wide ? 32'h1ffff : 32'h1ff), rd_exp(d));
  endtask
  task automatic stat(input logic [1:0] e);
    i_eeprom_host_model.status(en, val);
    chk({30'h0, en, val}, {30'h0, e});
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    val = 1'b0;
    while (val !== 1'b1 && k < 100) begin
      i_eeprom_host_model.status(en, val);
      k++;
    end
    chk({30'h0, en, val}, 32'h3);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    sreg(4'h0);
    av(1'b0, 4'hc, 32'h0);
    chk(got, 32'h0);
    $display("test reset done");
    cmd(`OP_SPECIAL, sub_field(`SUB_ENABLE), 16'h0, 0, 0);
    sreg(4'h2);
    cmd(`OP_SPECIAL, sub_field(`SUB_BULK_ERASE), 16'h0, 0, 0);
    sreg(4'h7);
    wait_ready();
    adr = 10'(rnd());
    rd(adr, 16'h00ff);
    $display("test bulk erase done");
    cmd(`OP_SPECIAL, sub_field(`SUB_DISABLE), 16'h0, 0, 0);
    dat = 16'(rnd());
    cmd(`OP_WRITE, adr_field(adr), {8'h00, dat[7:0]}, 8, 0);
    sreg(4'h0);
    rd(adr, 16'h00ff);
    $display("test disabled done");
    cmd(`OP_SPECIAL, sub_field(`SUB_ENABLE), 16'h0, 0, 0);
    cmd(`OP_WRITE, adr_field(adr), {8'h00, dat[7:0]}, 8, 0);
    stat(2'h2);
    wait_ready();
    cmd(`OP_READ, adr_field(adr), 16'h0, 0, 16);
    chk(got & 32'h1ffff, {16'h0000, dat[7:0], 8'hff});
    $display("test write done");
    cmd(`OP_ERASE, adr_field(adr), 16'h0, 0, 0);
    sreg(4'h7);
    repeat (2300) @(posedge mclk);
    stat(2'h3);
    i_eeprom_host_model.send(1, 32'h1, got);
    stat(2'h0);
    rd(adr, 16'h00ff);
    $display("test erase done");
    dat = 16'(rnd());
    cmd(`OP_SPECIAL, sub_field(`SUB_BULK_WRITE), {8'h00, dat[7:0]}, 8, 0);
    wait_ready();
    rd(10'(rnd()), {8'h00, dat[7:0]});
    $display("test bulk write done");
    i_eeprom_host_model.set_wide(1'b1);
    repeat (4) @(posedge mclk);
    sreg(4'ha);
    av(1'b1, `REG_CONFIG, {30'h0, `WSZ_FIXED8});
    sreg(4'h2);
    av(1'b1, `REG_CONFIG, 32'h0);
    adr = 10'(rnd()) & 10'h1ff;
    dat = 16'(rnd());
    cmd(`OP_WRITE, adr_field(adr), dat, 16, 0);
    wait_ready();
    rd(adr, dat);
    cmd(`OP_SPECIAL, sub_field(`SUB_DISABLE), 16'h0, 0, 0);
    sreg(4'h8);
    $display("test wide done");
    give_verdict();
  end
endmodule
